// >>> rtl/codec_ctrl_defs.vh
// constants for the codec control byte interpreter
`ifndef CODEC_CTRL_DEFS_VH
`define CODEC_CTRL_DEFS_VH

// control byte fields
`define CB_ADDR_BIT 7
`define CB_READ_BIT 6
`define CB_POWER_BIT 5
`define CB_CONF_BIT 4
`define CB_CLASS_HI 3
`define CB_CLASS_LO 2

// class codes seen on bits 3..2
`define CLASS_NORMAL 2'h3
`define CLASS_STATUS 2'h1
`define CLASS_COEF 2'h0

// length select codes
`define LENGTH_SELECT_FIELD_NONE 2'h0
`define LENGTH_SELECT_FIELD_UNUSED 2'h1
`define LENGTH_SELECT_FIELD_BOTH 2'h2
`define LENGTH_SELECT_FIELD_ONE 2'h3

// configuration register resets
`define CFG1_RESET 8'h00
`define CFG2_RESET 8'hFF

// register one fields
`define CFG1_B_DIS 7
`define CFG1_Z_RES 6
`define CFG1_TM_HI 2

// register two fields
`define CFG2_DIR_D 7
`define CFG2_DIR_A 4
`define CFG2_EXP 3
`define CFG2_AM 2
`define CFG2_MU 1
`define CFG2_PCS 0

// test modes
`define TM_NONE 3'h0
`define TM_UNUSED4 3'h4
`define TM_UNUSED5 3'h5

// coefficient opcodes, codec A, low six bits
`define OP_B1 6'h03
`define OP_B2 6'h0B
`define OP_BDLY 6'h18
`define OP_Z 6'h13
`define OP_X 6'h23
`define OP_R 6'h2B
`define OP_GAIN 6'h30

// section byte counts
`define LEN_FILTER 4'h8
`define LEN_SHORT 4'h4

`endif

// >>> rtl/codec_ctrl_interp.v
// control byte interpreter for the codec serial interface line
`timescale 1ns/1ps
`include "codec_ctrl_defs.vh"
module codec_ctrl_interp #(
	parameter AW = 6
) (
	input wire clk, // 40 MHz system clock
	input wire reset, // hardware reset pin, active high
	input wire codec_b_select, // this codec answers as B when the reg two AM bit is low
	input wire [7:0] rx_byte, // byte from serial line
	input wire rx_valid, // byte strobe
	output reg [7:0] tx_byte_q, // byte back to serial line
	output reg tx_valid_q, // reply strobe
	output reg busy_q, // reply in progress
	output reg [1:0] last_class_q, // class of last command
	output reg [7:0] filter_and_test_config_q, // config reg one
	output reg [7:0] signaling_and_coding_config_q, // config reg two
	output reg power_bit_q, // operating when high
	output reg conference_sum_bit_q, // sum channels A and B
	output reg [4:0] filter_enable_q, // B,Z,X,R,G enables
	output reg [2:0] test_mode_q, // active test mode
	output reg [3:0] pin_is_input_q, // D,C,B,A directions
	output reg expansion_attached_q, // expansion logic present
	output reg mu_law_q, // mu-law when high, A-law low
	output reg fixed_coefficient_q, // fixed B coefficients
	input wire [AW-1:0] coef_addr, // filter engine read address
	output wire [7:0] coef_data_q // filter engine read data
);

// ==========================================================
// states
// ==========================================================
localparam ST_IDLE = 3'd0;
localparam ST_WR_CFG = 3'd1;
localparam ST_WR_COEF = 3'd2;
localparam ST_SKIP = 3'd3;
localparam ST_RD_COEF = 3'd4;
localparam ST_RD_CFG = 3'd5;

// ST_IDLE waits for a control byte and decodes its class
// ST_WR_CFG stores status write data into the config regs
// ST_WR_COEF fills one coefficient section byte by byte
// ST_SKIP swallows data addressed to the other codec
// ST_RD_COEF walks one section out of the memory
// ST_RD_CFG sends reg two and/or reg one back to the line
// a read holds busy high so no byte is taken in mid-reply

// byte flow in short:
// a control byte is only ever decoded in ST_IDLE; every data byte
// that follows it is counted down in cnt_q, so a lost strobe on the
// line leaves the sequencer waiting rather than misreading data as
// a new command. bytes for the other codec are still counted so
// that both codecs on one port stay in step with the stream.
// replies are never interleaved with input: the partner must wait
// for busy to drop before it sends the next command.
// the memory has a registered read, so the reply lags the address
// by one cycle and rd_vld_q follows the read state for that reason.

reg [2:0] state_q;
reg [3:0] cnt_q;
reg [2:0] sec_q;
reg [2:0] off_q;
reg rd_vld_q;

wire own_addr;
wire [3:0] op_dec;
wire [3:0] op_len;
wire [3:0] length_select_field_len;
wire [1:0] cls;
wire mem_we;
wire [AW-1:0] mem_addr;
wire [7:0] mem_rdata;

// ==========================================================
// decode helpers
// ==========================================================
// all decoding below except own_addr is purely from the live byte, so a control
// byte is classified in the very cycle its strobe is seen
// map a coefficient opcode to {valid, section}
function [3:0] sec_of;
	input [5:0] op;
	begin
		case (op)
		`OP_B1: sec_of = 4'h8;
		`OP_B2: sec_of = 4'h9;
		`OP_BDLY: sec_of = 4'hA;
		`OP_Z: sec_of = 4'hB;
		`OP_X: sec_of = 4'hC;
		`OP_R: sec_of = 4'hD;
		`OP_GAIN: sec_of = 4'hE;
		default: sec_of = 4'h0;
		endcase
	end
endfunction

// byte count of a coefficient section
function [3:0] sec_len;
	input [2:0] sec;
	begin
		case (sec)
		3'd2: sec_len = `LEN_SHORT;
		3'd6: sec_len = `LEN_SHORT;
		default: sec_len = `LEN_FILTER;
		endcase
	end
endfunction

// number of bytes following a status write
function [3:0] length_select_field_count;
	input [1:0] length_select_field;
	begin
		case (length_select_field)
		`LENGTH_SELECT_FIELD_BOTH: length_select_field_count = 4'h2;
		`LENGTH_SELECT_FIELD_ONE: length_select_field_count = 4'h1;
		default: length_select_field_count = 4'h0;
		endcase
	end
endfunction

// codec address: a single codec always answers to zero
assign own_addr = signaling_and_coding_config_q[`CFG2_AM] ?
	1'b0 : codec_b_select;
assign cls = rx_byte[`CB_CLASS_HI:`CB_CLASS_LO];
assign op_dec = sec_of(rx_byte[5:0]);
assign op_len = sec_len(op_dec[2:0]);
assign length_select_field_len = length_select_field_count(rx_byte[1:0]);

// memory port: write during fill, read during reply
// one shared address serves both, which is safe because a fill and
// a reply can never overlap in this sequencer
assign mem_we = rx_valid && (state_q == ST_WR_COEF);
assign mem_addr = {sec_q, off_q};

coef_mem #(
	.AW(AW),
	.DW(8)
) u_coef_mem (
	.clk(clk),
	.we(mem_we),
	.waddr(mem_addr),
	.wdata(rx_byte),
	.raddr_a(mem_addr),
	.rdata_a(mem_rdata),
	.raddr_b(coef_addr),
	.rdata_b(coef_data_q)
);

// ==========================================================
// command sequencer
// ==========================================================
// takes control bytes and their data, produces replies
// tx_valid_q defaults low each cycle so every reply byte is a
// single-cycle strobe; the memory path and the register path both
// raise it, but the register path waits until the memory path has
// gone quiet, so the two never collide on tx_byte_q
always @(posedge clk or posedge reset) begin
	if (reset) begin
		state_q <= ST_IDLE;
		cnt_q <= 4'h0;
		sec_q <= 3'h0;
		off_q <= 3'h0;
		rd_vld_q <= 1'b0;
		tx_byte_q <= 8'h00;
		tx_valid_q <= 1'b0;
		busy_q <= 1'b0;
		last_class_q <= 2'h0;
		power_bit_q <= 1'b0;
		conference_sum_bit_q <= 1'b0;
		filter_and_test_config_q <= `CFG1_RESET;
		signaling_and_coding_config_q <= `CFG2_RESET;
	end else begin
		tx_valid_q <= 1'b0;
		rd_vld_q <= (state_q == ST_RD_COEF);
		// memory data lands one cycle after its address
		if (rd_vld_q) begin
			tx_byte_q <= mem_rdata;
			tx_valid_q <= 1'b1;
		end
		case (state_q)
		ST_IDLE: begin
			if (rx_valid) begin
				last_class_q <= cls;
				if (cls == `CLASS_NORMAL) begin
					state_q <= ST_IDLE;
				end else if (rx_byte[`CB_CLASS_LO]) begin
					// status operation
					if (rx_byte[`CB_ADDR_BIT] != own_addr) begin
						if (!rx_byte[`CB_READ_BIT] &&
							length_select_field_len != 4'h0) begin
							cnt_q <= length_select_field_len;
							state_q <= ST_SKIP;
						end
					end else begin
						power_bit_q <= rx_byte[`CB_POWER_BIT];
						conference_sum_bit_q <=
							rx_byte[`CB_CONF_BIT];
						if (rx_byte[`CB_READ_BIT]) begin
							if (length_select_field_len != 4'h0) begin
								cnt_q <= length_select_field_len;
								state_q <= ST_RD_CFG;
								busy_q <= 1'b1;
							end
						end else if (length_select_field_len != 4'h0) begin
							cnt_q <= length_select_field_len;
							state_q <= ST_WR_CFG;
						end
					end
				end else if (op_dec[3]) begin
					// coefficient operation
					sec_q <= op_dec[2:0];
					off_q <= 3'h0;
					cnt_q <= op_len;
					if (rx_byte[`CB_ADDR_BIT] != own_addr) begin
						if (!rx_byte[`CB_READ_BIT]) begin
							state_q <= ST_SKIP;
						end
					end else if (rx_byte[`CB_READ_BIT]) begin
						state_q <= ST_RD_COEF;
						busy_q <= 1'b1;
					end else begin
						state_q <= ST_WR_COEF;
					end
				end
			end
		end
		ST_WR_CFG: begin
			if (rx_valid) begin
				// with two bytes the first goes to reg two
				if (cnt_q == 4'h2) begin
					signaling_and_coding_config_q <= rx_byte;
				end else begin
					filter_and_test_config_q <= rx_byte;
				end
				cnt_q <= cnt_q - 4'h1;
				if (cnt_q == 4'h1) begin
					state_q <= ST_IDLE;
				end
			end
		end
		ST_WR_COEF: begin
			if (rx_valid) begin
				off_q <= off_q + 3'h1;
				cnt_q <= cnt_q - 4'h1;
				if (cnt_q == 4'h1) begin
					state_q <= ST_IDLE;
				end
			end
		end
		ST_SKIP: begin
			// data meant for the other codec is swallowed
			if (rx_valid) begin
				cnt_q <= cnt_q - 4'h1;
				if (cnt_q == 4'h1) begin
					state_q <= ST_IDLE;
				end
			end
		end
		ST_RD_COEF: begin
			off_q <= off_q + 3'h1;
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q == 4'h1) begin
				cnt_q <= 4'h2; // coefficients then both regs
				state_q <= ST_RD_CFG;
			end
		end
		ST_RD_CFG: begin
			// wait for the last memory byte to leave first
			if (!rd_vld_q) begin
				tx_valid_q <= 1'b1;
				if (cnt_q == 4'h2) begin
					tx_byte_q <= signaling_and_coding_config_q;
				end else begin
					tx_byte_q <= filter_and_test_config_q;
				end
				cnt_q <= cnt_q - 4'h1;
				if (cnt_q == 4'h1) begin
					state_q <= ST_IDLE;
					busy_q <= 1'b0;
				end
			end
		end
		default: begin
			state_q <= ST_IDLE;
			busy_q <= 1'b0;
		end
		endcase
	end
end

// ==========================================================
// decoded configuration
// ==========================================================
// the decoded outputs trail the config regs by one cycle, so every
// consumer sees a register write land whole, never half of it
wire [2:0] tm_field;
wire tm_unused;

// test mode field and its two unused codes
assign tm_field = filter_and_test_config_q[`CFG1_TM_HI:0];
assign tm_unused = (tm_field == `TM_UNUSED4) ||
	(tm_field == `TM_UNUSED5);

// filter enables: B has an active high disable, the rest restore
always @(posedge clk or posedge reset) begin
	if (reset) begin
		filter_enable_q <= 5'h10;
	end else begin
		filter_enable_q[4] <=
			~filter_and_test_config_q[`CFG1_B_DIS];
		filter_enable_q[3:0] <=
			filter_and_test_config_q[`CFG1_Z_RES:3];
	end
end

// test mode: an unused code must not reach the analog side
always @(posedge clk or posedge reset) begin
	if (reset) begin
		test_mode_q <= `TM_NONE;
	end else if (tm_unused) begin
		test_mode_q <= `TM_NONE;
	end else begin
		test_mode_q <= tm_field;
	end
end

// signaling pin directions, D down to A
always @(posedge clk or posedge reset) begin
	if (reset) begin
		pin_is_input_q <= 4'hF;
	end else begin
		pin_is_input_q[3:1] <= signaling_and_coding_config_q[
			`CFG2_DIR_D:`CFG2_DIR_A+1];
		// two codecs on one port: pin A carries the codec address,
		// so it must listen whatever its direction bit says
		pin_is_input_q[0] <=
			signaling_and_coding_config_q[`CFG2_DIR_A] |
			~signaling_and_coding_config_q[`CFG2_AM];
	end
end

// expansion logic, coding law and B coefficient source
always @(posedge clk or posedge reset) begin
	if (reset) begin
		expansion_attached_q <= 1'b1;
		mu_law_q <= 1'b1;
		fixed_coefficient_q <= 1'b1;
	end else begin
		expansion_attached_q <=
			signaling_and_coding_config_q[`CFG2_EXP];
		mu_law_q <= signaling_and_coding_config_q[`CFG2_MU];
		fixed_coefficient_q <=
			signaling_and_coding_config_q[`CFG2_PCS];
	end
end

endmodule

// >>> rtl/coef_mem.v
// coefficient memory with one write and two registered read ports
`timescale 1ns/1ps
module coef_mem #(
	parameter AW = 6,
	parameter DW = 8
) (
	input wire clk, // system clock
	input wire we, // write strobe
	input wire [AW-1:0] waddr, // write address
	input wire [DW-1:0] wdata, // write data
	input wire [AW-1:0] raddr_a, // read address, port a
	output reg [DW-1:0] rdata_a, // read data, port a
	input wire [AW-1:0] raddr_b, // read address, port b
	output reg [DW-1:0] rdata_b // read data, port b
);

reg [DW-1:0] mem [0:(1<<AW)-1];

// write, then registered reads
always @(posedge clk) begin
	if (we) begin
		mem[waddr] <= wdata;
	end
	rdata_a <= mem[raddr_a];
	rdata_b <= mem[raddr_b];
end

endmodule

// >>> sim/codec_ctrl_asserts.sv
// port assertions for the control byte interpreter
`timescale 1ns/1ps
module codec_ctrl_asserts (
	input wire clk, // clock
	input wire reset, // async reset
	input wire [7:0] rx_byte, // byte in
	input wire rx_valid, // byte strobe
	input wire tx_valid_q, // reply strobe
	input wire busy_q, // reply busy
	input wire [7:0] filter_and_test_config_q, // reg one
	input wire [7:0] signaling_and_coding_config_q, // reg two
	input wire power_bit_q, // power
	input wire conference_sum_bit_q, // conference
	input wire [4:0] filter_enable_q, // enables
	input wire [2:0] test_mode_q, // test mode
	input wire [3:0] pin_is_input_q, // directions
	input wire mu_law_q // coding law
);
	wire [7:0] c1 = filter_and_test_config_q;
	wire [7:0] c2 = signaling_and_coding_config_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ========
	// checks
	property p_rst;
		@(negedge reset) c1 == 8'h00 && c2 == 8'hFF;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset");
	property p_pwr;
		$changed({power_bit_q, conference_sum_bit_q}) |-> $past(rx_valid)
			&& {power_bit_q, conference_sum_bit_q} == $past(rx_byte[5:4]);
	endproperty
	a_pwr: assert property (p_pwr) else $error("bad power");
	property p_cfg2;
		$changed(c2) |-> $past(rx_valid) && c2 == $past(rx_byte);
	endproperty
	a_cfg2: assert property (p_cfg2) else $error("bad reg two");
	property p_cfg1;
		$changed(c1) |-> $past(rx_valid) && c1 == $past(rx_byte);
	endproperty
	a_cfg1: assert property (p_cfg1) else $error("bad reg one");
	property p_tm;
		test_mode_q == ($past(c1[2:1]) == 2'b10 ? 3'h0 : $past(c1[2:0]));
	endproperty
	a_tm: assert property (p_tm) else $error("bad test mode");
	property p_pin;
		pin_is_input_q == $past({c2[7:5], c2[4] | ~c2[2]});
	endproperty
	a_pin: assert property (p_pin) else $error("bad pins");
	property p_filt;
		filter_enable_q == $past({~c1[7], c1[6:3]})
			&& mu_law_q == $past(c2[1]);
	endproperty
	a_filt: assert property (p_filt) else $error("bad filters");
	property p_reply;
		$rose(busy_q) |-> ##[1:2] tx_valid_q ##1 tx_valid_q;
	endproperty
	a_reply: assert property (p_reply) else $error("no reply");
	c_read: cover property ($rose(busy_q));
	c_cfg: cover property ($changed(c2));
	c_pwr: cover property ($rose(power_bit_q));
endmodule

// >>> sim/pcm_port_model.sv
// controller port model that feeds the serial line
`timescale 1ns/1ps
module pcm_port_model (
	input wire clk, // clock
	input wire busy_q, // device busy
	input wire [7:0] tx_byte_q, // reply byte
	input wire tx_valid_q, // reply strobe
	output logic [7:0] rx_byte, // byte out
	output logic rx_valid // byte strobe
);
	logic [7:0] got[$];
	initial begin
		rx_byte = 8'h00;
		rx_valid = 1'b0;
	end
	// collect reply bytes
	always @(posedge clk) begin
		if (tx_valid_q === 1'b1)
			got.push_back(tx_byte_q);
	end
	// whole frame, idle line shows inverted data
	task automatic send(input logic [7:0] b[$], input int gap);
		int w;
		w = 0;
		while (busy_q !== 1'b0 && w < 100) begin
			@(negedge clk);
			w++;
		end
		foreach (b[i]) begin
			@(negedge clk);
			rx_byte = b[i];
			rx_valid = 1'b1;
			repeat (gap) begin
				@(negedge clk);
				rx_valid = 1'b0;
				rx_byte = ~rx_byte;
			end
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_byte = ~rx_byte;
	endtask
endmodule

// >>> sim/testbench.sv
// self-checking bench for the control byte interpreter
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic codec_b_select = 1'b0;
	logic [5:0] coef_addr = 6'h00;
	wire [7:0] rx_byte, tx_byte_q, cfg1, cfg2, cdata;
	wire rx_valid, tx_valid_q, busy_q, pwr, conf, expn, mu, fixd;
	wire [4:0] fen;
	wire [3:0] pin;
	wire [2:0] tm;
	wire [1:0] lc;
	int error_cnt = 0;
	int tests_run = 0;
	logic [7:0] ops[7] = '{8'h03, 8'h0B, 8'h18, 8'h13, 8'h23, 8'h2B, 8'h30};
	// ========
	// clock and units
	always #12.5 clk = ~clk;
	pcm_port_model P (.clk, .busy_q, .tx_byte_q, .tx_valid_q, .rx_byte,
		.rx_valid);
	codec_ctrl_interp DUT (.clk, .reset, .codec_b_select, .rx_byte,
		.rx_valid, .tx_byte_q, .tx_valid_q, .busy_q, .last_class_q(lc),
		.filter_and_test_config_q(cfg1), .signaling_and_coding_config_q(cfg2),
		.power_bit_q(pwr), .conference_sum_bit_q(conf), .filter_enable_q(fen),
		.test_mode_q(tm), .pin_is_input_q(pin), .expansion_attached_q(expn),
		.mu_law_q(mu), .fixed_coefficient_q(fixd), .coef_addr,
		.coef_data_q(cdata));
	// compare and count
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic finish_test();
		if (error_cnt == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// read command, then compare the reply bytes
	task automatic rd(input logic [7:0] cmd, input logic [7:0] e[$]);
		int w;
		P.got.delete();
		P.send('{cmd}, 0);
		w = 0;
		while (P.got.size() < e.size() && w < 50) begin
			@(negedge clk);
			w++;
		end
		foreach (e[i]) chk(P.got[i], e[i]);
	endtask
	// ========
	// main sequence
	initial begin
		logic [7:0] d[$];
		repeat (20) @(negedge clk);
		reset = 1'b0;
		chk(cfg1, 8'h00);
		chk(cfg2, 8'hFF);
		P.send('{8'h26, 8'hF4, 8'h80}, 0);
		@(negedge clk);
		chk({cfg1[7:1], pwr}, 8'h81);
		chk({fen, lc}, 7'h01);
		rd(8'h66, '{8'hF4, 8'h80});
		P.send('{8'h0C}, 1);
		@(negedge clk);
		chk({pwr, lc}, 3'h7);
		for (int m = 0; m < 8; m++) begin
			P.send('{8'h37, {5'h0F, m[2:0]}}, 0);
			@(negedge clk);
			chk({fen, tm}, {5'h1F, m[2:1] == 2'b10 ? 3'h0 : m[2:0]});
			chk(cfg2, 8'hF4);
		end
		chk({pwr, conf}, 2'h3);
		P.send('{8'h26, 8'h0A, 8'h78}, 0);
		repeat (2) @(negedge clk);
		chk({pin, expn, mu, fixd}, 7'h0E);
		P.send('{8'hA6, 8'hF4, 8'h00}, 0);
		chk(cfg2, 8'h0A);
		P.send('{8'h26, 8'h05, 8'h78}, 0);
		repeat (2) @(negedge clk);
		chk({pin, expn, mu, fixd}, 7'h01);
		foreach (ops[k]) begin
			d = {};
			for (int i = 0; i < ((k == 2 || k == 6) ? 4 : 8); i++)
				d.push_back(ops[k] + 8'(i));
			P.send({ops[k], d}, 0);
			d.push_back(8'h05);
			d.push_back(8'h78);
			rd(ops[k] | 8'h40, d);
		end
		chk(lc, 2'h0);
		coef_addr = 6'h1F;
		repeat (2) @(negedge clk);
		chk(cdata, 8'h1A);
		reset = 1'b1;
		@(negedge clk);
		chk(cfg1, 8'h00);
		chk(cfg2, 8'hFF);
		finish_test();
	end
	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		error_cnt++;
		finish_test();
	end
endmodule
bind codec_ctrl_interp codec_ctrl_asserts chk_i (.clk, .reset, .rx_byte,
	.rx_valid, .tx_valid_q, .busy_q, .filter_and_test_config_q,
	.signaling_and_coding_config_q, .power_bit_q, .conference_sum_bit_q,
	.filter_enable_q, .test_mode_q, .pin_is_input_q, .mu_law_q);
